// File: rtl/fpm_pkg.sv
package fpm_pkg;

  // link framing: 4 command bits then 16 payload bits, lsb first
  localparam int FRAME_BITS = 20;
  localparam logic [4:0] BIT_LAST = 5'h13;
  localparam logic [4:0] BIT_CMD_LAST = 5'h03;
  localparam logic [4:0] BIT_OPERAND_LAST = 5'h0B;

  // four-bit link commands
  localparam logic [3:0] CMD_CORE = 4'h0;
  localparam logic [3:0] CMD_READ_INC = 4'h9;
  localparam logic [3:0] CMD_WRITE_INC = 4'hD;
  localparam logic [3:0] CMD_WRITE_PROG = 4'hF;

  // core instruction opcodes and operands
  localparam logic [7:0] OP_LOAD_LITERAL = 8'h0E;
  localparam logic [7:0] OP_STORE_WREG = 8'h6E;
  localparam logic [7:0] OP_CLEAR_REG = 8'h6A;
  localparam logic [7:0] ADDR_PTR_UPPER = 8'hF8;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'hF7;
  localparam logic [7:0] ADDR_PTR_LOW = 8'hF6;
  localparam logic [15:0] INSN_SET_PERMIT = 16'h84A6;
  localparam logic [15:0] INSN_SET_ERASE_SEL = 16'h88A6;
  localparam logic [15:0] INSN_SET_START = 16'h82A6;
  localparam logic [15:0] INSN_CLR_PERMIT = 16'h94A6;

  // pointer and buffer geometry
  localparam int PTR_W = 22;
  localparam int BUF_WORDS = 32;
  localparam int BUF_AW = 5;
  localparam logic [4:0] BUF_LAST = 5'h1F;
  localparam logic [PTR_W-1:0] PTR_STEP_WORD = 22'h000002;
  localparam logic [PTR_W-1:0] PTR_STEP_BYTE = 22'h000001;
  localparam logic [PTR_W-1:0] PAGE_MASK = 22'h3FFC00;

  // internally timed operations, figures in ns
  localparam int SYS_PERIOD_NS = 25;
  localparam int ERASE_HOLD_TIME_NS = 10000;
  localparam int PROGRAM_HOLD_TIME_NS = 5000;
  localparam int ERASE_HOLD_CYC = (ERASE_HOLD_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int PROGRAM_HOLD_CYC = (PROGRAM_HOLD_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int HOLD_W = 12;

  // register map, byte addresses
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_POINTER = 4'h8;
  localparam int CTRL_LINK_EN = 0;
  localparam int STAT_PERMIT = 0;
  localparam int STAT_ERASE_SEL = 1;
  localparam int STAT_BUSY = 2;

  typedef struct packed {
    logic [15:0] payload;
    logic [3:0] cmd;
  } fpm_frame_t;

  typedef struct packed {
    logic en;
    logic [PTR_W-1:0] addr;
    logic [15:0] data;
  } fpm_wr_t;

endpackage : fpm_pkg

// File: rtl/fpm_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser; output moves only once stages two and three agree
module fpm_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // stage one feeds stage two only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule : fpm_sync
`default_nettype wire

// File: rtl/fpm_wbuf.sv
`timescale 1ns/10ps
`default_nettype none
// 64-byte write buffer as 32 half-words, registered read port
module fpm_wbuf
  import fpm_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [BUF_AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [BUF_AW-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [BUF_WORDS];

  // contents survive programming, so stale words are rewritten unless refilled
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : fpm_wbuf
`default_nettype wire

// File: rtl/fpm_flash_seq.sv
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - permit and erase-select bits are set by core instructions; erase is then armed.
// - start bit launches erase; device times it internally from the system clock.
// - each buffered byte lands at the location selected by the pointer.
// - two-byte writes advance the pointer by two, 32 writes fill the buffer.
// - last two-byte write also starts programming, timed internally by the device.
// - command 1101 writes two bytes and adds two; 1111 writes and programs.
// - 64-byte buffer keeps its contents; a program needs only the changed words refilled.
// - command 1001 returns the pointed byte on clocks 12 to 19, pointer plus one.
module fpm_flash_seq (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SERIAL_PROG_CLOCK,
  input wire logic SERIAL_PROG_IO_IN,
  output logic SERIAL_PROG_IO_OUT,
  output logic SERIAL_PROG_IO_OE,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [fpm_pkg::PTR_W-1:0] FLASH_RD_ADDR,
  input wire logic [7:0] FLASH_RD_DATA,
  output logic FLASH_ERASE,
  output logic [fpm_pkg::PTR_W-1:0] FLASH_ERASE_ADDR,
  output fpm_pkg::fpm_wr_t FLASH_WR,
  output logic FLASH_BUSY,
  output logic NVM_MODIFY_PERMIT
);
  import fpm_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ERASE = 4'h2,
    ST_FILL = 4'h4,
    ST_HOLD = 4'h8
  } fpm_state_t;

  // ---------------- link clock domain ----------------
  logic [4:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] shift_d;
  fpm_frame_t frame_q;
  logic req_tgl_q;
  logic is_read_q;
  logic [7:0] out_sh_q;

  assign shift_d = {SERIAL_PROG_IO_IN, shift_q[FRAME_BITS-1:1]};

  // bits arrive lsb first; link clock may stop between frames, so the frame
  // is closed on its own last edge and nothing waits for a later one
  always_ff @(posedge SERIAL_PROG_CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      bit_cnt_q <= 5'h00;
      shift_q <= '0;
      frame_q <= '0;
      req_tgl_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      if (bit_cnt_q == BIT_LAST) begin
        bit_cnt_q <= 5'h00;
        frame_q <= fpm_frame_t'(shift_d);
        req_tgl_q <= ~req_tgl_q;
      end else begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  logic [7:0] read_byte_q;

  // read reply: turn the pin round after the 8th operand clock
  always_ff @(posedge SERIAL_PROG_CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      is_read_q <= 1'b0;
      out_sh_q <= 8'h00;
      SERIAL_PROG_IO_OUT <= 1'b0;
      SERIAL_PROG_IO_OE <= 1'b0;
    end else begin
      if (bit_cnt_q == BIT_CMD_LAST) begin
        is_read_q <= (shift_d[FRAME_BITS-1:FRAME_BITS-4] == CMD_READ_INC);
      end
      if (bit_cnt_q == BIT_OPERAND_LAST && is_read_q) begin
        // quasi-static: read_byte_q settles long before this edge of a read frame
        out_sh_q <= {1'b0, read_byte_q[7:1]};
        SERIAL_PROG_IO_OUT <= read_byte_q[0];
        SERIAL_PROG_IO_OE <= 1'b1;
      end else if (bit_cnt_q == BIT_LAST) begin
        SERIAL_PROG_IO_OE <= 1'b0;
        SERIAL_PROG_IO_OUT <= 1'b0;
      end else if (SERIAL_PROG_IO_OE) begin
        SERIAL_PROG_IO_OUT <= out_sh_q[0];
        out_sh_q <= {1'b0, out_sh_q[7:1]};
      end
    end
  end

  // ---------------- system clock domain ----------------
  logic req_lvl;
  logic req_seen_q;
  logic frame_evt;

  fpm_sync u_req_sync (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .async_in(req_tgl_q),
    .level_out(req_lvl)
  );

  assign frame_evt = req_lvl ^ req_seen_q;

  // toggle edge marks a finished frame; frame_q is stable for a whole frame time
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_seen_q <= 1'b0;
    end else begin
      req_seen_q <= req_lvl;
    end
  end

  logic link_en_q;
  logic [7:0] wreg_q;
  logic [PTR_W-1:0] ptr_q;
  logic erase_sel_q;
  fpm_state_t state_q;
  logic [HOLD_W-1:0] hold_q;
  logic [BUF_AW-1:0] fill_idx_q;
  logic pend_q;
  logic [BUF_AW-1:0] pend_idx_q;
  logic [15:0] buf_rdata;
  logic cmd_ok;
  logic [3:0] cmd;
  logic [15:0] pay;
  logic buf_we;
  logic start_req;

  assign cmd = frame_q.cmd;
  assign pay = frame_q.payload;
  assign cmd_ok = frame_evt && link_en_q;
  // buffer writes are refused while the array is being programmed or erased
  assign buf_we = cmd_ok && state_q == ST_IDLE &&
                  (cmd == CMD_WRITE_INC || cmd == CMD_WRITE_PROG);
  assign start_req = cmd_ok && state_q == ST_IDLE && NVM_MODIFY_PERMIT &&
                     ((cmd == CMD_CORE && pay == INSN_SET_START) ||
                      cmd == CMD_WRITE_PROG);

  fpm_wbuf u_wbuf (
    .clk(SYS_CLK),
    .we(buf_we),
    .waddr(ptr_q[BUF_AW:1]),
    .wdata(pay),
    .raddr(fill_idx_q),
    .rdata(buf_rdata)
  );

  // working register and table pointer
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wreg_q <= 8'h00;
      ptr_q <= '0;
    end else if (cmd_ok) begin
      case (cmd)
        CMD_CORE: begin
          if (pay[15:8] == OP_LOAD_LITERAL) begin
            wreg_q <= pay[7:0];
          end else if (pay[15:8] == OP_STORE_WREG || pay[15:8] == OP_CLEAR_REG) begin
            // clearing stores zero, storing copies the working register
            case (pay[7:0])
              ADDR_PTR_UPPER: begin
                ptr_q[21:16] <= (pay[15:8] == OP_STORE_WREG) ? wreg_q[5:0] : 6'h00;
              end
              ADDR_PTR_HIGH: begin
                ptr_q[15:8] <= (pay[15:8] == OP_STORE_WREG) ? wreg_q : 8'h00;
              end
              ADDR_PTR_LOW: begin
                ptr_q[7:0] <= (pay[15:8] == OP_STORE_WREG) ? wreg_q : 8'h00;
              end
              default: begin
              end
            endcase
          end
        end
        CMD_WRITE_INC: begin
          if (buf_we) begin
            ptr_q <= ptr_q + PTR_STEP_WORD;
          end
        end
        CMD_READ_INC: begin
          ptr_q <= ptr_q + PTR_STEP_BYTE;
        end
        default: begin
        end
      endcase
    end
  end

  // control bits: permit and erase select
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      NVM_MODIFY_PERMIT <= 1'b0;
      erase_sel_q <= 1'b0;
    end else begin
      if (cmd_ok && cmd == CMD_CORE && pay == INSN_SET_PERMIT) begin
        NVM_MODIFY_PERMIT <= 1'b1;
      end else if (cmd_ok && cmd == CMD_CORE && pay == INSN_CLR_PERMIT) begin
        NVM_MODIFY_PERMIT <= 1'b0;
      end
      if (cmd_ok && cmd == CMD_CORE && pay == INSN_SET_ERASE_SEL) begin
        erase_sel_q <= 1'b1;
      end else if (state_q == ST_ERASE) begin
        erase_sel_q <= 1'b0; // one erase per arming
      end
    end
  end

  // operation sequencer: erase, or buffer scan then program hold
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      hold_q <= '0;
      fill_idx_q <= '0;
      pend_q <= 1'b0;
      pend_idx_q <= '0;
      FLASH_BUSY <= 1'b0;
    end else begin
      pend_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_req && cmd == CMD_CORE && erase_sel_q) begin
            state_q <= ST_ERASE;
            FLASH_BUSY <= 1'b1;
          end else if (start_req) begin
            state_q <= ST_FILL;
            fill_idx_q <= '0;
            FLASH_BUSY <= 1'b1;
          end
        end
        ST_ERASE: begin
          state_q <= ST_HOLD;
          hold_q <= HOLD_W'(ERASE_HOLD_CYC);
        end
        ST_FILL: begin
          // whole buffer goes out every time, old words included
          pend_q <= 1'b1;
          pend_idx_q <= fill_idx_q;
          if (fill_idx_q == BUF_LAST) begin
            state_q <= ST_HOLD;
            hold_q <= HOLD_W'(PROGRAM_HOLD_CYC);
          end else begin
            fill_idx_q <= fill_idx_q + 5'h01;
          end
        end
        ST_HOLD: begin
          if (hold_q <= HOLD_W'(1)) begin
            state_q <= ST_IDLE;
            FLASH_BUSY <= 1'b0;
          end else begin
            hold_q <= hold_q - HOLD_W'(1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
          FLASH_BUSY <= 1'b0;
        end
      endcase
    end
  end

  // array strobes toward the flash macro
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FLASH_ERASE <= 1'b0;
      FLASH_ERASE_ADDR <= '0;
      FLASH_WR <= '0;
    end else begin
      FLASH_ERASE <= (state_q == ST_ERASE);
      if (state_q == ST_ERASE) begin
        FLASH_ERASE_ADDR <= ptr_q & PAGE_MASK; // 1024-byte page
      end
      FLASH_WR.en <= pend_q;
      if (pend_q) begin
        FLASH_WR.addr <= {ptr_q[PTR_W-1:BUF_AW+1], pend_idx_q, 1'b0};
        FLASH_WR.data <= buf_rdata;
      end
    end
  end

  // byte at the pointer is kept prefetched for the next read frame
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FLASH_RD_ADDR <= '0;
      read_byte_q <= 8'h00;
    end else begin
      FLASH_RD_ADDR <= ptr_q;
      read_byte_q <= FLASH_RD_DATA;
    end
  end

  // avalon slave: one wait cycle, then answer
  logic ack_q;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_q <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      link_en_q <= 1'b1;
    end else begin
      ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
      if ((AVS_READ || AVS_WRITE) && !ack_q) begin
        AVS_READDATA <= 32'h00000000;
        if (AVS_READ) begin
          case (AVS_ADDRESS)
            REG_CONTROL: AVS_READDATA[CTRL_LINK_EN] <= link_en_q;
            REG_STATUS: begin
              AVS_READDATA[STAT_PERMIT] <= NVM_MODIFY_PERMIT;
              AVS_READDATA[STAT_ERASE_SEL] <= erase_sel_q;
              AVS_READDATA[STAT_BUSY] <= FLASH_BUSY;
            end
            REG_POINTER: AVS_READDATA[PTR_W-1:0] <= ptr_q;
            default: begin
            end
          endcase
        end
      end
      // a write lands on the edge where the master sees waitrequest low
      if (AVS_WRITE && ack_q && AVS_ADDRESS == REG_CONTROL) begin
        link_en_q <= AVS_WRITEDATA[CTRL_LINK_EN];
      end
    end
  end

endmodule : fpm_flash_seq
`default_nettype wire

// File: test/fpm_prog_model.sv
`timescale 1ns/10ps
`default_nettype none
// programmer side: clock idles low between frames, bits change while clock is low
module fpm_prog_model (
  output logic clk,
  output logic pin,
  input wire logic dev_out,
  input wire logic dev_oe
);
  logic d = 1'b0;
  logic oe = 1'b1;
  initial clk = 1'b0;
  // a released line shows the inverse of the last bit, never a stale copy
  assign pin = dev_oe ? dev_out : (oe ? d : ~d);
  // one 20-clock frame, lsb first; hold keeps the 4th clock high for a timed step
  task automatic frame(input logic [3:0] c, input logic [15:0] p, input int hold,
                       output logic [7:0] rb);
    logic [19:0] f;
    f = {p, c};
    #200;
    for (int i = 0; i < 20; i++) begin
      oe = !(c == 4'h9 && i >= 11);
      d = f[i];
      #6 clk = 1'b1;
      if (i == 3) #(hold);
      #6 clk = 1'b0;
      if (i >= 11 && i <= 18) rb[i-11] = pin;
    end
    oe = 1'b1;
  endtask : frame
endmodule : fpm_prog_model
`default_nettype wire

// File: test/fpm_flash_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// flash-side and bus timing checks of the sequencer
module fpm_chk
  import fpm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic FLASH_ERASE,
  input wire logic [fpm_pkg::PTR_W-1:0] FLASH_ERASE_ADDR,
  input wire fpm_pkg::fpm_wr_t FLASH_WR,
  input wire logic FLASH_BUSY,
  input wire logic NVM_MODIFY_PERMIT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // a burst word that is not the last of the 64-byte block
  sequence s_mid_word;
    FLASH_WR.en && FLASH_WR.addr[5:1] != BUF_LAST;
  endsequence
  sequence s_start;
    $rose(FLASH_BUSY);
  endsequence
  property p_ack; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  property p_ack_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  property p_permit; s_start |-> NVM_MODIFY_PERMIT; endproperty
  property p_erase_pg; FLASH_ERASE |-> FLASH_ERASE_ADDR[9:0] == 10'h000 && FLASH_BUSY; endproperty
  property p_erase_hold; FLASH_ERASE |=> FLASH_BUSY [*8]; endproperty
  property p_act; s_start |-> ##[0:2] (FLASH_ERASE || FLASH_WR.en); endproperty
  property p_base; $rose(FLASH_WR.en) |-> FLASH_WR.addr[5:0] == 6'h00; endproperty
  property p_step;
    s_mid_word |=> FLASH_WR.en && FLASH_WR.addr == $past(FLASH_WR.addr) + PTR_STEP_WORD;
  endproperty
  property p_wr_busy; FLASH_WR.en |-> FLASH_BUSY && NVM_MODIFY_PERMIT; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  a_ack_one: assert property (p_ack_one) else $error("bus answer too long");
  a_permit: assert property (p_permit) else $error("start without permit");
  a_erase_pg: assert property (p_erase_pg) else $error("erase not page based");
  a_erase_hold: assert property (p_erase_hold) else $error("erase not timed");
  a_act: assert property (p_act) else $error("busy without action");
  a_base: assert property (p_base) else $error("burst not block based");
  a_step: assert property (p_step) else $error("burst word skipped");
  a_wr_busy: assert property (p_wr_busy) else $error("write outside busy");
endmodule : fpm_chk
bind fpm_flash_seq fpm_chk u_chk (.*);
`default_nettype wire

// File: test/fpm_tb.sv
`timescale 1ns/10ps
`default_nettype none
// bench: bus driver, flash array pattern and a reference of each burst
module testbench;
  import fpm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, q;
  logic wreq, pclk, pin, io_out, io_oe, busy, permit, erase;
  logic [PTR_W-1:0] ra, ea, pg, bb;
  logic [7:0] rb;
  logic [15:0] w;
  fpm_wr_t fwr;
  fpm_wr_t wq [$];
  logic [PTR_W-1:0] eq [$];
  logic [15:0] ex [$];
  integer seed = 98;
  int failures = 0;
  int compares = 0;
  initial forever #12.5 clk = ~clk;
  fpm_flash_seq uut (.SYS_CLK(clk), .RESETN(rst_n), .SERIAL_PROG_CLOCK(pclk),
    .SERIAL_PROG_IO_IN(pin), .SERIAL_PROG_IO_OUT(io_out), .SERIAL_PROG_IO_OE(io_oe),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .FLASH_RD_ADDR(ra),
    .FLASH_RD_DATA(ra[7:0] ^ 8'h5A), .FLASH_ERASE(erase), .FLASH_ERASE_ADDR(ea),
    .FLASH_WR(fwr), .FLASH_BUSY(busy), .NVM_MODIFY_PERMIT(permit));
  fpm_prog_model prog (.clk(pclk), .pin(pin), .dev_out(io_out), .dev_oe(io_oe));
  // record what the sequencer hands to the flash array
  always @(posedge clk) begin
    if (fwr.en === 1'b1) wq.push_back(fwr);
    if (erase === 1'b1) eq.push_back(ea);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request held until waitrequest is sampled low
  task automatic bus(input logic wn, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !wn;
    wr <= wn;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rchk
  task automatic fr(input logic [3:0] c, input logic [15:0] p, input int h = 0);
    prog.frame(c, p, h, rb);
    // a frame needs up to six system clocks to cross before its effect shows
    repeat (8) @(posedge clk);
  endtask : fr
  task automatic setptr(input logic [PTR_W-1:0] a);
    fr(CMD_CORE, {OP_LOAD_LITERAL, 2'b00, a[21:16]});
    fr(CMD_CORE, {OP_STORE_WREG, ADDR_PTR_UPPER});
    fr(CMD_CORE, {OP_LOAD_LITERAL, a[15:8]});
    fr(CMD_CORE, {OP_STORE_WREG, ADDR_PTR_HIGH});
    fr(CMD_CORE, {OP_LOAD_LITERAL, a[7:0]});
    fr(CMD_CORE, {OP_STORE_WREG, ADDR_PTR_LOW});
    repeat (8) @(posedge clk);
  endtask : setptr
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) failures++;
  endtask : wait_idle
  // every burst word must match the reference buffer in order
  task automatic burst_chk;
    chk("burst length", 32, wq.size());
    foreach (wq[i]) begin
      chk("burst addr", bb + 2 * i, wq[i].addr);
      chk("burst data", ex[i], wq[i].data);
    end
    wq.delete();
  endtask : burst_chk
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(REG_CONTROL, 32'h1, "control");
    rchk(REG_STATUS, 32'h0, "status");
    rchk(4'hC, 32'h0, "unmapped");
    pg = $random(seed);
    pg = pg & PAGE_MASK;
    setptr(pg);
    rchk(REG_POINTER, pg, "pointer");
    for (int i = 0; i < 2; i++) begin
      fr(CMD_READ_INC, 16'h0000);
      chk("read byte", (i + pg[7:0]) ^ 8'h5A, rb);
    end
    rchk(REG_POINTER, pg + 2, "pointer");
    fr(CMD_CORE, INSN_SET_START);
    repeat (20) @(posedge clk);
    rchk(REG_STATUS, 32'h0, "status");
    // frames are dropped while the link is disabled
    bus(1'b1, REG_CONTROL, 32'h0);
    fr(CMD_CORE, INSN_SET_PERMIT);
    repeat (8) @(posedge clk);
    rchk(REG_STATUS, 32'h0, "status off");
    bus(1'b1, REG_CONTROL, 32'h1);
    fr(CMD_CORE, INSN_SET_PERMIT);
    fr(CMD_CORE, INSN_SET_ERASE_SEL);
    repeat (8) @(posedge clk);
    rchk(REG_STATUS, 32'h3, "status");
    fr(CMD_CORE, INSN_SET_START);
    fr(CMD_CORE, 16'h0000, ERASE_HOLD_TIME_NS);
    wait_idle();
    chk("erase count", 1, eq.size());
    chk("erase page", pg, eq[0]);
    bb = pg + PTR_W'(({$random(seed)} % 16) * 64);
    setptr(bb);
    wq.delete();
    for (int i = 0; i < 32; i++) begin
      w = (i == 5) ? 16'hFFFF : 16'($random(seed));
      ex.push_back(w);
      fr((i == 31) ? CMD_WRITE_PROG : CMD_WRITE_INC, w);
      if (i == 30) rchk(REG_POINTER, bb + 62, "pointer");
    end
    fr(CMD_CORE, 16'h0000, PROGRAM_HOLD_TIME_NS);
    wait_idle();
    burst_chk();
    // only the last word is reloaded, the rest must be retained
    setptr(bb + 62);
    ex[31] = 16'($random(seed));
    fr(CMD_WRITE_PROG, ex[31]);
    fr(CMD_CORE, 16'h0000, PROGRAM_HOLD_TIME_NS);
    wait_idle();
    burst_chk();
    fr(CMD_CORE, INSN_CLR_PERMIT);
    fr(CMD_WRITE_PROG, 16'h1234);
    repeat (20) @(posedge clk);
    chk("no burst", 0, wq.size());
    rchk(REG_STATUS, 32'h0, "status");
    // clearing a pointer byte stores zero in it
    fr(CMD_CORE, {OP_CLEAR_REG, ADDR_PTR_LOW});
    rchk(REG_POINTER, {bb[21:8], 8'h00}, "pointer clear");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
